// ---- hdl/bmc_top.sv ----
// burst modulation control core with its register file and bus slave
`timescale 1ns/1ns

// Operation
// [R1] only one modulation type active; enabling burst turns the previous one off
// [R2] software enables burst last, after all other settings are made
// [R3] mode select: internal gives counted bursts, external gives gated bursts
// [R4] counted burst starts on selected trigger, lasts programmed cycle count
// [R5] counted mode never bursts without a trigger from the selected source
// [R6] gated burst runs while gate is high, stops when gate goes low
// [R7] internal trigger source uses the repetition timer set by repeat rate
// [R8] trigger source resets to the internal repetition timer
// [R9] trigger_choice_a source request while burst is on selects the external connector
// [R10] bus source triggers on bus trigger message or trigger command
// [R11] backplane source picks one of eight lines, zero through seven
// [R12] external source uses front connector shared with frequency-shift keying
// [R13] connector or backplane trigger starts on rising edge, ignores repeat rate
// [R14] gated: waveform while gate high, dc offset held while gate low
// [R15] cycle count 1 to 50000 or infinite, reset to one cycle
// [R16] counted: sync low during burst, high after it until next burst
// [R17] triggers during a running burst are ignored until it completes
module bmc_top
  import bmc_pkg::*;
#(
  parameter logic [31:0] RATE_PERIOD = RATE_PERIOD_DEFAULT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // trigger and gate pins
  input wire logic ext_trig_pin,
  input wire logic [7:0] backplane_trigger_line,
  // host bus and waveform engine
  input wire logic bus_get_msg,
  input wire logic wave_cycle_done,
  // waveform control
  output logic wave_run,
  output logic hold_offset,
  output logic sync_out,
  output logic [15:0] burst_start_phase,
  output bmc_pkg::bmc_mod_t active_mod
);
  import bmc_pkg::*;

  bmc_reg_if rif ();

  bmc_src_t trigger_source_select, next_src;
  bmc_mod_t next_mod;
  bmc_state_t state, next_state;
  logic burst_mode_select, next_mode;
  logic [2:0] line_sel, next_line;
  logic [15:0] burst_cycle_count, next_count;
  logic count_inf, next_inf;
  logic [31:0] burst_repeat_rate, next_rate;
  logic [15:0] next_phase;
  logic [15:0] left, next_left;
  logic bus_trig, next_bus_trig;
  logic next_wave_run, next_hold, next_sync;
  logic [8:0] pin_s1, pin_s2, pin_prev;
  logic [8:0] pin_rise, pin_raw;
  logic burst_on, gated, timer_tick, trig, gate_level;
  bmc_src_t eff_src;
  logic [31:0] ctrl_rd, wr_ctrl, wr_count, wr_phase;
  logic [15:0] cnt_in;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave and repetition timer
  bmc_axil u_axil (
    .mclk(mclk),
    .nrst(nrst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif)
  );

  bmc_timer u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .run(burst_on && !gated && eff_src == SRC_INT),  // R7
    .period(burst_repeat_rate),
    .tick(timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; bit 8 is the front connector
  assign pin_raw = {ext_trig_pin, backplane_trigger_line};
  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          pin_s1[g] <= 1'b0;
          pin_s2[g] <= 1'b0;
          pin_prev[g] <= 1'b0;
        end else begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_prev[g] <= pin_s2[g];
        end
      end
      assign pin_rise[g] = pin_s2[g] && !pin_prev[g];  // R13
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // source decode
  assign burst_on = (active_mod == MOD_BURST);
  assign gated = burst_mode_select;  // R3

  always_comb begin
    eff_src = trigger_source_select;
    if (trigger_source_select == SRC_CHOICE_A) begin
      eff_src = SRC_EXT;  // R9
    end
    if (gated && eff_src != SRC_BACKPLANE) begin
      eff_src = SRC_EXT;
    end
  end

  // one of eight backplane lines, else the shared front connector
  assign gate_level = (eff_src == SRC_BACKPLANE) ? pin_s2[line_sel] : pin_s2[8];  // R11 R12

  always_comb begin
    case (eff_src)
      SRC_INT: trig = timer_tick;  // R7
      SRC_EXT: trig = pin_rise[8];  // R12 R13
      SRC_BUS: trig = bus_trig || bus_get_msg;  // R10
      SRC_BACKPLANE: trig = pin_rise[line_sel];  // R11 R13
      default: trig = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counted burst sequencer
  always_comb begin
    next_state = state;
    next_left = left;
    if (!burst_on || gated) begin
      next_state = ST_IDLE;
      next_left = 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trig) begin  // R5
            next_state = ST_BURST;  // R4
            next_left = burst_cycle_count;
          end
        end
        ST_BURST: begin
          // triggers are not looked at here
          if (wave_cycle_done && !count_inf) begin  // R17
            if (left <= 16'h0001) begin
              next_state = ST_IDLE;  // R4
              next_left = 16'h0000;
            end else begin
              next_left = left - 16'h0001;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    if (!burst_on) begin
      next_wave_run = 1'b1;
      next_hold = 1'b0;
      next_sync = 1'b1;
    end else if (gated) begin
      next_wave_run = gate_level;  // R6 R14
      next_hold = !gate_level;  // R14
      next_sync = gate_level;
    end else begin
      next_wave_run = (next_state == ST_BURST);
      next_hold = (next_state != ST_BURST);
      next_sync = (next_state != ST_BURST);  // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes
  assign wr_ctrl = bmc_merge(ctrl_rd, rif.wr_data, rif.wr_strb);
  assign wr_count = bmc_merge({15'h0000, count_inf, burst_cycle_count}, rif.wr_data,
                              rif.wr_strb);
  assign cnt_in = wr_count[15:0];
  assign wr_phase = bmc_merge({16'h0000, burst_start_phase}, rif.wr_data, rif.wr_strb);

  always_comb begin
    next_mod = active_mod;
    next_mode = burst_mode_select;
    next_src = trigger_source_select;
    next_line = line_sel;
    next_count = burst_cycle_count;
    next_inf = count_inf;
    next_rate = burst_repeat_rate;
    next_phase = burst_start_phase;
    next_bus_trig = 1'b0;
    if (rif.wr_en) begin
      case (rif.wr_addr)
        ADDR_CTRL: begin
          next_mode = wr_ctrl[CTRL_MODE_BIT];
          next_line = wr_ctrl[CTRL_LINE_LSB +: 3];
          if (wr_ctrl[CTRL_EN_BIT]) begin
            next_mod = MOD_BURST;  // R1
          end else if (wr_ctrl[CTRL_MOD_LSB +: 3] >= MOD_BURST) begin
            next_mod = MOD_NONE;
          end else begin
            next_mod = bmc_mod_t'(wr_ctrl[CTRL_MOD_LSB +: 3]);  // R1
          end
          if (wr_ctrl[CTRL_SRC_LSB +: 3] > SRC_CHOICE_A) begin
            next_src = trigger_source_select;
          end else if (wr_ctrl[CTRL_SRC_LSB +: 3] == SRC_CHOICE_A &&
                       (next_mod == MOD_BURST)) begin
            next_src = SRC_EXT;  // R9
          end else begin
            next_src = bmc_src_t'(wr_ctrl[CTRL_SRC_LSB +: 3]);
          end
        end
        ADDR_COUNT: begin
          next_inf = wr_count[COUNT_INF_BIT];  // R15
          if (cnt_in < CYCLE_MIN) begin
            next_count = CYCLE_MIN;  // R15
          end else if (cnt_in > CYCLE_MAX) begin
            next_count = CYCLE_MAX;  // R15
          end else begin
            next_count = cnt_in;
          end
        end
        ADDR_RATE: begin
          next_rate = bmc_merge(burst_repeat_rate, rif.wr_data, rif.wr_strb);
          if (next_rate == 32'h0000_0000) begin
            next_rate = 32'h0000_0001;
          end
        end
        ADDR_TRIG: next_bus_trig = 1'b1;  // R10
        ADDR_PHASE: begin
          next_phase = wr_phase[15:0];
        end
        default: next_bus_trig = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[CTRL_EN_BIT] = burst_on;
    ctrl_rd[CTRL_MODE_BIT] = burst_mode_select;
    ctrl_rd[CTRL_SRC_LSB +: 3] = trigger_source_select;
    ctrl_rd[CTRL_LINE_LSB +: 3] = line_sel;
    ctrl_rd[CTRL_MOD_LSB +: 3] = active_mod;
    case (rif.rd_addr)
      ADDR_CTRL: rif.rd_data = ctrl_rd;
      ADDR_COUNT: rif.rd_data = {15'h0000, count_inf, burst_cycle_count};
      ADDR_RATE: rif.rd_data = burst_repeat_rate;
      ADDR_PHASE: rif.rd_data = {16'h0000, burst_start_phase};
      ADDR_STATUS: begin
        rif.rd_data = 32'h0000_0000;
        rif.rd_data[STAT_BURST_BIT] = (state == ST_BURST);
        rif.rd_data[STAT_SYNC_BIT] = sync_out;
        rif.rd_data[STAT_GATE_BIT] = gate_level;
        rif.rd_data[STAT_RUN_BIT] = wave_run;
        rif.rd_data[STAT_LEFT_LSB +: 16] = left;
      end
      default: rif.rd_data = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      active_mod <= MOD_NONE;
      burst_mode_select <= 1'b0;
      trigger_source_select <= SRC_INT;  // R8
      line_sel <= 3'h0;
      burst_cycle_count <= CYCLE_RESET;  // R15
      count_inf <= 1'b0;
      burst_repeat_rate <= RATE_PERIOD;
      burst_start_phase <= PHASE_RESET;
      bus_trig <= 1'b0;
      state <= ST_IDLE;
      left <= 16'h0000;
      wave_run <= 1'b1;
      hold_offset <= 1'b0;
      sync_out <= 1'b1;
    end else begin
      active_mod <= next_mod;
      burst_mode_select <= next_mode;
      trigger_source_select <= next_src;
      line_sel <= next_line;
      burst_cycle_count <= next_count;
      count_inf <= next_inf;
      burst_repeat_rate <= next_rate;
      burst_start_phase <= next_phase;
      bus_trig <= next_bus_trig;
      state <= next_state;
      left <= next_left;
      wave_run <= next_wave_run;
      hold_offset <= next_hold;
      sync_out <= next_sync;
    end
  end

endmodule : bmc_top

// ---- hdl/bmc_pkg.sv ----
// constants, types and helpers shared by the burst modulation control block
package bmc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int RATE_DEFAULT_HZ = 100;
  localparam int RATE_PERIOD_DEFAULT = CLK_FREQ_HZ / RATE_DEFAULT_HZ;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_RATE = 8'h08;
  localparam logic [7:0] ADDR_TRIG = 8'h0C;
  localparam logic [7:0] ADDR_PHASE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_LINE_LSB = 8;
  localparam int CTRL_MOD_LSB = 12;
  localparam int COUNT_INF_BIT = 16;
  localparam int STAT_BURST_BIT = 0;
  localparam int STAT_SYNC_BIT = 1;
  localparam int STAT_GATE_BIT = 2;
  localparam int STAT_RUN_BIT = 3;
  localparam int STAT_LEFT_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and limits
  localparam logic [15:0] CYCLE_MIN = 16'h0001;
  localparam logic [15:0] CYCLE_MAX = 16'hC350;
  localparam logic [15:0] CYCLE_RESET = 16'h0001;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [2:0] {
    SRC_INT,
    SRC_EXT,
    SRC_BUS,
    SRC_BACKPLANE,
    SRC_CHOICE_A
  } bmc_src_t;

  typedef enum logic [2:0] {
    MOD_NONE,
    MOD_AM,
    MOD_FM,
    MOD_FSK,
    MOD_BURST
  } bmc_mod_t;

  typedef enum logic {
    ST_IDLE,
    ST_BURST
  } bmc_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic bmc_addr_known(input logic [7:0] a);
    bmc_addr_known = (a == ADDR_CTRL) || (a == ADDR_COUNT) || (a == ADDR_RATE) ||
                     (a == ADDR_TRIG) || (a == ADDR_PHASE) || (a == ADDR_STATUS);
  endfunction : bmc_addr_known

  function automatic logic [31:0] bmc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      bmc_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : bmc_merge

endpackage : bmc_pkg

// ---- hdl/bmc_reg_if.sv ----
// register access carrier between the bus slave and the burst control core
`timescale 1ns/1ns
interface bmc_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb,
               output rd_addr, input rd_data);
  modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb,
                input rd_addr, output rd_data);
endinterface : bmc_reg_if

// ---- hdl/bmc_axil.sv ----
// axi4-lite slave that turns bus transfers into single-cycle register accesses
`timescale 1ns/1ns
module bmc_axil
  import bmc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  bmc_reg_if.bus rif
);
  import bmc_pkg::*;

  logic aw_full, w_full, next_aw_full, next_w_full;
  logic [7:0] aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic [3:0] s_q, next_s_q;
  logic next_bvalid, next_rvalid, do_wr;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // write path: address and data taken in either order
  assign do_wr = aw_full && w_full && !bvalid;
  assign rif.wr_en = do_wr;
  assign rif.wr_addr = aw_q;
  assign rif.wr_data = w_q;
  assign rif.wr_strb = s_q;
  assign rif.rd_addr = araddr;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_q = aw_q;
    next_w_q = w_q;
    next_s_q = s_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (awvalid && awready) begin
      next_aw_full = 1'b1;
      next_aw_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_full = 1'b1;
      next_w_q = wdata;
      next_s_q = wstrb;
    end
    if (do_wr) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = bmc_addr_known(aw_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: one cycle from address to data
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = bmc_addr_known(araddr) ? rif.rd_data : 32'h0000_0000;
      next_rresp = bmc_addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      s_q <= next_s_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      awready <= !next_aw_full && !next_bvalid && !(awvalid && awready);
      wready <= !next_w_full && !next_bvalid && !(wvalid && wready);
      arready <= !next_rvalid && !(arvalid && arready);
    end
  end

endmodule : bmc_axil

// ---- hdl/bmc_timer.sv ----
// repetition timer that pulses once per programmed period while running
`timescale 1ns/1ns
module bmc_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic run,
  input wire logic [31:0] period,
  // event
  output logic tick
);

  logic [31:0] cnt, next_cnt;
  logic next_tick;

  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = 32'h0000_0000;
    end else if (cnt + 32'h0000_0001 >= period) begin
      next_cnt = 32'h0000_0000;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule : bmc_timer

// ---- tb/bmc_top_assertions.sv ----
// concurrent checks on the burst control top ports
`timescale 1ns/1ns
module bmc_top_assertions
  import bmc_pkg::*;
#(
  parameter logic [31:0] RATE_PERIOD = RATE_PERIOD_DEFAULT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // bus handshakes
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // waveform control
  input wire logic wave_run,
  input wire logic hold_offset,
  input wire logic sync_out,
  input wire bmc_pkg::bmc_mod_t active_mod
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  sequence s_rd_wait;
    rvalid && !rready;
  endsequence
  property p_rst;
    disable iff (1'b0) !nrst |=> active_mod == MOD_NONE && sync_out && wave_run && !hold_offset;
  endproperty
  property p_rans;
    s_rd_take |=> rvalid;
  endproperty
  property p_rhold;
    s_rd_wait |=> rvalid && $stable(rdata);
  endproperty
  property p_rblk;
    rvalid |-> !arready;
  endproperty
  property p_wblk;
    bvalid |-> !awready && !wready;
  endproperty
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_hold;
    hold_offset == !wave_run;
  endproperty
  property p_off;
    active_mod != MOD_BURST && $past(active_mod) != MOD_BURST |-> wave_run && sync_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_rans: assert property (p_rans) else $error("read answer late");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_rblk: assert property (p_rblk) else $error("read taken while pending");
  a_wblk: assert property (p_wblk) else $error("write taken while pending");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_hold: assert property (p_hold) else $error("offset hold mismatch");
  a_off: assert property (p_off) else $error("output gated with burst off");
endmodule : bmc_top_assertions
bind bmc_top bmc_top_assertions #(.RATE_PERIOD(RATE_PERIOD)) u_chk (.mclk(mclk), .nrst(nrst),
  .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .wave_run(wave_run), .hold_offset(hold_offset), .sync_out(sync_out), .active_mod(active_mod));

// ---- tb/bmc_wave_model.sv ----
// waveform engine model: one cycle-done pulse per waveform period
`timescale 1ns/1ns
module bmc_wave_model (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // engine control
  input wire logic wave_run,
  input wire logic slow,
  // engine event
  output logic wave_cycle_done
);
  int cnt;
  always @(posedge mclk) begin
    if (!nrst || !wave_run) begin
      cnt <= 0;
      wave_cycle_done <= 1'b0;
    end else begin
      cnt <= (cnt >= (slow ? 6 : 2)) ? 0 : cnt + 1;
      wave_cycle_done <= (cnt == (slow ? 6 : 2));
    end
  end
endmodule : bmc_wave_model

// ---- tb/burst_modulation_control_bench.sv ----
// self-checking bench for the burst modulation control top
`timescale 1ns/1ns
module burst_modulation_control_bench;
  import bmc_pkg::*;
  localparam logic [31:0] RP = 32'h0000_0014;
  logic mclk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, ext = 1'b0, get = 1'b0, slow = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0, bpl = '0;
  logic [31:0] wdata = '0, rd_v, r, seed = 32'h0000_80b7;
  logic awready, wready, bvalid, arready, rvalid, wave_run, hold_offset, sync_out, done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] phase;
  bmc_mod_t mod;
  int error_cnt = 0, samples_checked = 0, n;
  always #10 mclk = ~mclk;
  bmc_top #(.RATE_PERIOD(RP)) u_dut (.mclk(mclk), .nrst(nrst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ext_trig_pin(ext), .backplane_trigger_line(bpl), .bus_get_msg(get),
    .wave_cycle_done(done), .wave_run(wave_run), .hold_offset(hold_offset),
    .sync_out(sync_out), .burst_start_phase(phase), .active_mod(mod));
  bmc_wave_model u_wave (.mclk(mclk), .nrst(nrst), .wave_run(wave_run), .slow(slow),
    .wave_cycle_done(done));
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd_v = rdata;
    chk(32'(rresp), 32'(er));
  endtask : rd
  task automatic pulse_get();
    @(posedge mclk);
    get <= 1'b1;
    @(posedge mclk);
    get <= 1'b0;
  endtask : pulse_get
  // measures one counted burst in waveform cycles
  task automatic burst(input int k);
    int t, c;
    t = 0;
    c = 0;
    while (sync_out !== 1'b0 && t < 60) begin
      @(negedge mclk);
      t++;
    end
    chk(32'({wave_run, hold_offset}), 32'h0000_0002);
    while (sync_out === 1'b0 && c < 99) begin
      if (done === 1'b1) c++;
      @(negedge mclk);
    end
    chk(32'(c), 32'(k));
  endtask : burst
  task automatic quiet(input int k);
    int f;
    f = 0;
    repeat (k) begin
      @(negedge mclk);
      if (sync_out !== 1'b1) f = 1;
    end
    chk(32'(f), 32'h0000_0000);
  endtask : quiet
  initial begin
    #600000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    rd(ADDR_CTRL, RESP_OKAY);
    chk(rd_v & 32'h0000_0073, 32'h0000_0000);
    rd(ADDR_COUNT, RESP_OKAY);
    chk(rd_v, 32'h0000_0001);
    rd(ADDR_RATE, RESP_OKAY);
    chk(rd_v, RP);
    rd(8'h18, RESP_SLVERR);
    chk(rd_v, 32'h0000_0000);
    wr(8'h18, 32'h0000_0001, RESP_SLVERR);
    wr(ADDR_COUNT, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_COUNT, RESP_OKAY);
    chk(rd_v, 32'h0000_0001);
    wr(ADDR_COUNT, 32'h0000_c351, RESP_OKAY);
    rd(ADDR_COUNT, RESP_OKAY);
    chk(rd_v, 32'h0000_c350);
    wr(ADDR_CTRL, 32'h0000_2000, RESP_OKAY);
    chk(32'(mod), 32'(MOD_FM));
    r = rnd();
    wr(ADDR_PHASE, r, RESP_OKAY);
    chk(32'(phase), 32'(r[15:0]));
    r = rnd();
    n = int'(r[1:0]) + 1;
    slow <= 1'b1;
    wr(ADDR_COUNT, 32'(n), RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0021, RESP_OKAY);
    chk(32'(mod), 32'(MOD_BURST));
    quiet(40);
    pulse_get();
    fork
      burst(n);
      begin
        repeat (3) @(posedge mclk);
        pulse_get();
      end
    join
    quiet(30);
    wr(ADDR_TRIG, 32'h0000_0000, RESP_OKAY);
    burst(n);
    wr(ADDR_CTRL, 32'h0000_0011, RESP_OKAY);
    @(posedge mclk);
    ext <= 1'b1;
    burst(n);
    quiet(20);
    @(posedge mclk);
    ext <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL, 32'h0000_0031 | (i << 8), RESP_OKAY);
      bpl <= 8'(1 << ((i + 1) % 8));
      quiet(15);
      @(posedge mclk);
      bpl <= bpl | 8'(1 << i);
      burst(n);
      @(posedge mclk);
      bpl <= 8'h00;
    end
    wr(ADDR_CTRL, 32'h0000_0041, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY);
    chk(rd_v & 32'h0000_0073, 32'h0000_0011);
    slow <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    burst(n);
    burst(n);
    wr(ADDR_CTRL, 32'h0000_0013, RESP_OKAY);
    repeat (5) @(negedge mclk);
    chk(32'({wave_run, hold_offset, sync_out}), 32'h0000_0002);
    @(posedge mclk);
    ext <= 1'b1;
    repeat (5) @(negedge mclk);
    chk(32'({wave_run, hold_offset, sync_out}), 32'h0000_0005);
    rd(ADDR_STATUS, RESP_OKAY);
    chk(rd_v, 32'h0000_000e);
    ext <= 1'b0;
    repeat (5) @(negedge mclk);
    chk(32'({wave_run, hold_offset, sync_out}), 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    @(negedge mclk);
    chk({29'(mod), wave_run, hold_offset, sync_out}, 32'h0000_0005);
    end_of_test();
  end
endmodule : burst_modulation_control_bench
